// ---- cib_boot_select.sv ----
// Boot entry decision from port conditions, fuse and software vector.
module cib_boot_select (
    // Stored boot configuration
    input  wire cib_pkg::cib_bootcfg_t cfg,
    // Synchronised port levels
    input  wire logic [7:0]            portA,
    input  wire logic [7:0]            portB,
    input  wire logic [1:0]            portC,
    // Decision
    output logic                       hwCond,
    output cib_pkg::cib_target_t       target,
    output logic [15:0]                startAddr
);

    // ------------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------------
    // A condition byte left at all ones is unused, so the next port is tried.
    always_comb begin
        if (cfg.pa != cib_pkg::BYTE_ANY) begin
            hwCond = (portA == cfg.pa);
        end else if (cfg.pb != cib_pkg::BYTE_ANY) begin
            hwCond = (portB == cfg.pb);
        end else if (cfg.pc != cib_pkg::BYTE_ANY) begin
            hwCond = (portC == cfg.pc[1:0]);
        end else begin
            hwCond = 1'b0;
        end
        if (hwCond) begin
            target    = cib_pkg::TGT_ISP;
            startAddr = cib_pkg::BOOT_ADDR;
        end else if (!cfg.fuse && cfg.soft_boot_vector == cib_pkg::SBV_RST) begin
            target    = cib_pkg::TGT_ISP;
            startAddr = cib_pkg::BOOT_ADDR;
        end else if (!cfg.fuse) begin
            target    = cib_pkg::TGT_USER;
            startAddr = {cfg.soft_boot_vector, cib_pkg::LOW_BYTE};
        end else begin
            target    = cib_pkg::TGT_APP;
            startAddr = cib_pkg::APP_ADDR;
        end
    end

endmodule

// ---- cib_boot_session.sv ----
// CAN boot entry and programming session layer with its register file.
//
// Contract
// - A user bootloader starts at vector value as high byte, 00h low.
// - Out of reset enter bootloader when boot condition holds; factory: port A FEh.
// - Condition is user-set on ports A, B or C bits 0..1, fixed priority.
// - Restart into bootloader only with fuse at 0; fuse at 1 is locked.
// - Only standard frames with 11-bit identifiers are used.
// - Extra byte FFh runs autobaud; otherwise load the three bit-timing bytes.
// - During autobaud no frame is acknowledged until timing is found.
// - A frame carries a 4-bit length and zero to eight bytes.
// - Identifier is 7-bit base then 4-bit command code 0h..6h; only 0h..5h are acted on, 6h is ignored.
// - Identifier base resets to 00h, is writable, never above 7Fh.
// - Select-node accepted for node FFh or the local node number.
// - Reply holds two bytes: version, then 00h closed or 01h open.
// - With session closed, every frame but select-node is ignored.
module cib_boot_session #(
    parameter logic [7:0] BOOT_VERSION = 8'h10
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Avalon-MM slave
    input  wire logic [5:0]           avsAddress,
    input  wire logic                 avsRead,
    input  wire logic                 avsWrite,
    input  wire logic [31:0]          avsWriteData,
    input  wire logic [3:0]           avsByteEnable,
    output logic [31:0]               avsReadData,
    output logic                      avsWaitRequest,
    // Boot port pins
    input  wire logic [7:0]           port1Pin,
    input  wire logic [7:0]           port3Pin,
    input  wire logic [1:0]           port4Pin,
    // Boot decision
    output logic                      bootValid,
    output cib_pkg::cib_target_t      bootTarget,
    output logic [15:0]               bootAddr,
    // CAN controller setup
    input  wire logic                 baudFound,
    output logic                      autobaudRun,
    output logic                      ackEnable,
    output logic                      btLoad,
    output logic [23:0]               bitTiming,
    // Received frames
    input  wire logic                 rxValid,
    input  wire cib_pkg::cib_frame_t  rxFrame,
    // Frames to send
    output logic                      txValid,
    output cib_pkg::cib_frame_t       txFrame,
    input  wire logic                 txReady,
    // Session and memory commands
    output logic                      sessionOpen,
    output logic                      cmdValid,
    output cib_pkg::cib_frame_t       cmdFrame
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cib_pkg::cib_state_t  r_reg;
    cib_pkg::cib_state_t  r_next;
    logic                 hwCond;
    cib_pkg::cib_target_t decTarget;
    logic [15:0]          decAddr;
    logic                 busWr;
    logic                 restartWr;
    logic                 rxHit;
    logic                 selReq;
    logic                 selAccept;
    logic [7:0]           reqNode;

    function automatic logic [31:0] zx8(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction

    cib_boot_select u_select (
        .cfg       (r_reg.cfg),
        .portA     (r_reg.pAs2),
        .portB     (r_reg.pBs2),
        .portC     (r_reg.pCs2),
        .hwCond    (hwCond),
        .target    (decTarget),
        .startAddr (decAddr)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign busWr     = avsWrite && !r_reg.waitReq && avsByteEnable[0];
    assign restartWr = busWr && avsAddress == cib_pkg::OFS_CTRL
                       && avsWriteData[cib_pkg::CTRL_RESTART] && !r_reg.cfg.fuse;
    // Extended frames and foreign identifier groups never reach the session.
    assign rxHit     = rxValid && !rxFrame.ext && r_reg.phase == cib_pkg::ST_RUN
                       && cib_pkg::baseOf(rxFrame.id) == r_reg.base;
    assign reqNode   = rxFrame.data[7:0];
    assign selReq    = rxHit && cib_pkg::cmdOf(rxFrame.id) == cib_pkg::CMD_SELECT
                       && rxFrame.dlc != cib_pkg::DLC_NONE;
    assign selAccept = selReq && (reqNode == cib_pkg::BYTE_ANY || reqNode == r_reg.node);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_next          = r_reg;
        r_next.pAs1     = port1Pin;
        r_next.pAs2     = r_reg.pAs1;
        r_next.pBs1     = port3Pin;
        r_next.pBs2     = r_reg.pBs1;
        r_next.pCs1     = port4Pin;
        r_next.pCs2     = r_reg.pCs1;
        r_next.btLoad   = 1'b0;
        r_next.cmdValid = 1'b0;
        r_next.waitReq  = !((avsRead || avsWrite) && r_reg.waitReq);
        if (avsRead && r_reg.waitReq) begin
            case (avsAddress)
                cib_pkg::OFS_SBV:    r_next.rdata = zx8(r_reg.cfg.soft_boot_vector);
                cib_pkg::OFS_PA:     r_next.rdata = zx8(r_reg.cfg.pa);
                cib_pkg::OFS_PB:     r_next.rdata = zx8(r_reg.cfg.pb);
                cib_pkg::OFS_PC:     r_next.rdata = zx8(r_reg.cfg.pc);
                cib_pkg::OFS_FUSE:   r_next.rdata = {31'h0000_0000, r_reg.cfg.fuse};
                cib_pkg::OFS_EXTRA:  r_next.rdata = zx8(r_reg.extra);
                cib_pkg::OFS_BT1:    r_next.rdata = zx8(r_reg.bt1);
                cib_pkg::OFS_BT2:    r_next.rdata = zx8(r_reg.bt2);
                cib_pkg::OFS_BT3:    r_next.rdata = zx8(r_reg.bt3);
                cib_pkg::OFS_BASE:   r_next.rdata = {25'h000_0000, r_reg.base};
                cib_pkg::OFS_NODE:   r_next.rdata = zx8(r_reg.node);
                cib_pkg::OFS_STATUS: r_next.rdata = {26'h000_0000, r_reg.target,
                                                      r_reg.ackEn, r_reg.baudOk,
                                                      r_reg.session};
                default:             r_next.rdata = 32'h0000_0000;
            endcase
        end
        if (busWr) begin
            case (avsAddress)
                cib_pkg::OFS_SBV:   r_next.cfg.soft_boot_vector = avsWriteData[7:0];
                cib_pkg::OFS_PA:    r_next.cfg.pa  = avsWriteData[7:0];
                cib_pkg::OFS_PB:    r_next.cfg.pb  = avsWriteData[7:0];
                cib_pkg::OFS_PC:    r_next.cfg.pc  = avsWriteData[7:0];
                cib_pkg::OFS_FUSE: begin
                    if (!r_reg.cfg.fuse) begin
                        r_next.cfg.fuse = avsWriteData[cib_pkg::FUSE_BIT];
                    end
                end
                cib_pkg::OFS_EXTRA: r_next.extra = avsWriteData[7:0];
                cib_pkg::OFS_BT1:   r_next.bt1   = avsWriteData[7:0];
                cib_pkg::OFS_BT2:   r_next.bt2   = avsWriteData[7:0];
                cib_pkg::OFS_BT3:   r_next.bt3   = avsWriteData[7:0];
                cib_pkg::OFS_BASE:  r_next.base  = avsWriteData[6:0];
                cib_pkg::OFS_NODE:  r_next.node  = avsWriteData[7:0];
                default: ;
            endcase
        end
        unique case (r_reg.phase)
            cib_pkg::ST_BOOT: begin
                // Ports are read only once both synchroniser stages hold pin levels.
                if (r_reg.settle != 2'h0) begin
                    r_next.settle = r_reg.settle - 2'h1;
                    if (r_reg.settle == 2'h1) begin
                        r_next.bootValid = 1'b1;
                        r_next.target    = decTarget;
                        r_next.bootAddr  = decAddr;
                        if (decTarget == cib_pkg::TGT_ISP) begin
                            r_next.phase = cib_pkg::ST_BAUD;
                        end
                    end
                end
            end
            cib_pkg::ST_BAUD: begin
                if (r_reg.extra == cib_pkg::BYTE_ANY) begin
                    r_next.autoRun = !baudFound;
                    r_next.ackEn   = baudFound;
                    if (baudFound) begin
                        r_next.baudOk = 1'b1;
                        r_next.phase  = cib_pkg::ST_RUN;
                    end
                end else begin
                    r_next.btLoad  = 1'b1;
                    r_next.ackEn   = 1'b1;
                    r_next.phase   = cib_pkg::ST_RUN;
                end
            end
            cib_pkg::ST_RUN: begin
                if (selAccept) begin
                    r_next.session  = !r_reg.session;
                    r_next.tx.id    = cib_pkg::mkId(r_reg.base, cib_pkg::CMD_SELECT);
                    r_next.tx.ext   = 1'b0;
                    r_next.tx.dlc   = cib_pkg::REPLY_DLC;
                    r_next.tx.data  = {48'h0000_0000_0000,
                                       r_reg.session ? cib_pkg::SESS_CLOSED
                                                     : cib_pkg::SESS_OPEN,
                                       BOOT_VERSION};
                    r_next.txValid  = 1'b1;
                    r_next.phase    = cib_pkg::ST_REPLY;
                end else if (rxHit && r_reg.session
                             && cib_pkg::cmdOf(rxFrame.id) >= cib_pkg::CMD_PSTART
                             && cib_pkg::cmdOf(rxFrame.id) <= cib_pkg::CMD_READ) begin
                    r_next.cmdValid = 1'b1;
                    r_next.cmd      = rxFrame;
                end
            end
            cib_pkg::ST_REPLY: begin
                if (txReady) begin
                    r_next.txValid = 1'b0;
                    r_next.phase   = cib_pkg::ST_RUN;
                end
            end
            default: r_next.phase = cib_pkg::ST_BOOT;
        endcase
        if (restartWr) begin
            r_next.phase     = cib_pkg::ST_BOOT;
            r_next.settle    = cib_pkg::SETTLE;
            r_next.session   = 1'b0;
            r_next.bootValid = 1'b0;
            r_next.txValid   = 1'b0;
            r_next.autoRun   = 1'b0;
            r_next.ackEn     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= cib_pkg::RST_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avsReadData    = r_reg.rdata;
    assign avsWaitRequest = r_reg.waitReq;
    assign bootValid      = r_reg.bootValid;
    assign bootTarget     = r_reg.target;
    assign bootAddr       = r_reg.bootAddr;
    assign autobaudRun    = r_reg.autoRun;
    assign ackEnable      = r_reg.ackEn;
    assign btLoad         = r_reg.btLoad;
    assign bitTiming      = {r_reg.bt3, r_reg.bt2, r_reg.bt1};
    assign txValid        = r_reg.txValid;
    assign txFrame        = r_reg.tx;
    assign sessionOpen    = r_reg.session;
    assign cmdValid       = r_reg.cmdValid;
    assign cmdFrame       = r_reg.cmd;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_user_addr;
        $rose(r_reg.bootValid) && r_reg.target == cib_pkg::TGT_USER
            |-> r_reg.bootAddr == {r_reg.cfg.soft_boot_vector, cib_pkg::LOW_BYTE};
    endproperty
    a_user_addr: assert property (p_user_addr) else $error("user boot address wrong");

    property p_hw_boot;
        $rose(r_reg.bootValid) && $past(hwCond) |-> r_reg.target == cib_pkg::TGT_ISP;
    endproperty
    a_hw_boot: assert property (p_hw_boot) else $error("boot condition not honoured");

    property p_fuse_lock;
        r_reg.cfg.fuse |=> r_reg.cfg.fuse;
    endproperty
    a_fuse_lock: assert property (p_fuse_lock) else $error("locked fuse changed");

    property p_ext_ignore;
        rxValid && rxFrame.ext && !restartWr |=> !r_reg.cmdValid && $stable(r_reg.session);
    endproperty
    a_ext_ignore: assert property (p_ext_ignore) else $error("extended frame used");

    property p_stored_bt;
        r_reg.phase == cib_pkg::ST_BAUD && r_reg.extra != cib_pkg::BYTE_ANY && !restartWr
            |=> btLoad && !autobaudRun && ackEnable && r_reg.phase == cib_pkg::ST_RUN;
    endproperty
    a_stored_bt: assert property (p_stored_bt) else $error("stored timing not loaded");

    property p_no_ack;
        r_reg.phase == cib_pkg::ST_BAUD && r_reg.extra == cib_pkg::BYTE_ANY
            && !baudFound && !restartWr |=> autobaudRun && !ackEnable;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack during autobaud");

    property p_base_wr;
        busWr && avsAddress == cib_pkg::OFS_BASE |=> r_reg.base == $past(avsWriteData[6:0]);
    endproperty
    a_base_wr: assert property (p_base_wr) else $error("identifier base not written");

    property p_reject;
        selReq && !selAccept && !restartWr |=> $stable(r_reg.session) && !$rose(txValid);
    endproperty
    a_reject: assert property (p_reject) else $error("wrong node accepted");

    property p_reply;
        selAccept && !restartWr |=> txValid && txFrame.dlc == cib_pkg::REPLY_DLC
            && txFrame.data[7:0] == BOOT_VERSION
            && txFrame.data[15:8] == {7'h00, sessionOpen};
    endproperty
    a_reply: assert property (p_reply) else $error("select reply malformed");

    property p_closed;
        rxHit && !r_reg.session |=> !cmdValid;
    endproperty
    a_closed: assert property (p_closed) else $error("command taken while closed");

    property p_toggle;
        selAccept && !restartWr |=> sessionOpen != $past(sessionOpen);
    endproperty
    a_toggle: assert property (p_toggle) else $error("session did not toggle");

endmodule

// ---- cib_boot_session_bench.sv ----
// Self-checking bench of the CAN boot session block.
module cib_boot_session_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] BASE = 7'h12;
    logic clk = 1'b0, nrst = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, rxValid = 1'b0;
    logic [5:0]  avsAddress    = 6'h00;
    logic [31:0] avsWriteData  = 32'h0000_0000;
    logic [3:0]  avsByteEnable = 4'hF;
    logic [7:0]  port1Pin = 8'hFE, port3Pin = 8'hFF;
    logic [1:0]  port4Pin = 2'h3;
    cib_pkg::cib_frame_t  rxFrame = '0, txFrame, cmdFrame;
    cib_pkg::cib_target_t bootTarget;
    logic [31:0] avsReadData, rd;
    logic [15:0] bootAddr;
    logic [23:0] bitTiming;
    logic avsWaitRequest, bootValid, baudFound, autobaudRun, ackEnable, btLoad;
    logic txValid, txReady, sessionOpen, cmdValid;
    int err_total = 0, compares = 0, cycles = 0;
    cib_boot_session dut (.clk, .nrst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
        .avsByteEnable, .avsReadData, .avsWaitRequest, .port1Pin, .port3Pin, .port4Pin,
        .bootValid, .bootTarget, .bootAddr, .baudFound, .autobaudRun, .ackEnable, .btLoad,
        .bitTiming, .rxValid, .rxFrame, .txValid, .txFrame, .txReady, .sessionOpen,
        .cmdValid, .cmdFrame);
    cib_host_model host (.clk, .nrst, .autobaudRun, .txValid, .baudFound, .txReady);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress   <= a;
        avsWriteData <= {24'h00_0000, d};
        avsWrite     <= wr;
        avsRead      <= !wr;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
    endtask
    task automatic sendRx(input logic [3:0] c, input logic ext, input logic [7:0] b0);
        // The host repeats a frame until it is acknowledged, so none lands earlier.
        while (ackEnable !== 1'b1) @(posedge clk);
        @(posedge clk);
        rxValid <= 1'b1;
        rxFrame <= {BASE, c, ext, 4'h1, 56'h00_0000_0000_0000, b0};
        @(posedge clk);
        rxValid <= 1'b0;
        #1;
    endtask
    task automatic reply(input logic [7:0] st);
        chk(txFrame, {BASE, 4'h0, 1'b0, 4'h2, 48'h0000_0000_0000, st, 8'h10});
        do @(posedge clk); while (txValid !== 1'b0);
        chk(sessionOpen, st[0]);
    endtask
    task automatic waitBoot();
        do @(posedge clk); while (bootValid !== 1'b1);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_boot();
        waitBoot();
        chk({bootTarget, bootAddr, sessionOpen}, {3'b010, 16'hF800, 1'b0});
        do @(posedge clk); while (autobaudRun !== 1'b1);
        chk(ackEnable, 1'b0);
        do @(posedge clk); while (ackEnable !== 1'b1);
        chk(autobaudRun, 1'b0);
    endtask
    task automatic t_regs();
        bus(1'b0, cib_pkg::OFS_BASE, 8'h00);
        chk(rd, 32'h0000_0000);
        bus(1'b1, cib_pkg::OFS_BASE, 8'hFF);
        bus(1'b0, cib_pkg::OFS_BASE, 8'h00);
        chk(rd, 32'h0000_007F);
        bus(1'b0, 6'h3C, 8'h00);
        chk(rd, 32'h0000_0000);
        bus(1'b1, cib_pkg::OFS_BASE, {1'b0, BASE});
        bus(1'b1, cib_pkg::OFS_NODE, 8'h05);
    endtask
    task automatic t_session();
        sendRx(cib_pkg::CMD_READ, 1'b0, 8'h00);
        chk(cmdValid, 1'b0);
        sendRx(cib_pkg::CMD_SELECT, 1'b0, 8'h07);
        chk(txValid, 1'b0);
        sendRx(cib_pkg::CMD_SELECT, 1'b1, 8'hFF);
        chk(txValid, 1'b0);
        sendRx(cib_pkg::CMD_SELECT, 1'b0, 8'hFF);
        reply(8'h01);
        sendRx(cib_pkg::CMD_READ, 1'b0, 8'h00);
        chk({cmdValid, cmdFrame.id}, {1'b1, BASE, 4'h5});
        sendRx(4'h6, 1'b0, 8'h00);
        chk(cmdValid, 1'b0);
        sendRx(cib_pkg::CMD_SELECT, 1'b0, 8'h05);
        reply(8'h00);
    endtask
    task automatic t_restart();
        sendRx(cib_pkg::CMD_SELECT, 1'b0, 8'h05);
        reply(8'h01);
        bus(1'b1, cib_pkg::OFS_EXTRA, 8'h11);
        bus(1'b1, cib_pkg::OFS_BT1, 8'hA1);
        bus(1'b1, cib_pkg::OFS_BT2, 8'hB2);
        bus(1'b1, cib_pkg::OFS_BT3, 8'hC3);
        bus(1'b1, cib_pkg::OFS_CTRL, 8'h01);
        do @(posedge clk); while (btLoad !== 1'b1);
        chk({bitTiming, autobaudRun, sessionOpen}, {24'hC3_B2A1, 2'b00});
    endtask
    task automatic t_user();
        port1Pin <= 8'hFF;
        bus(1'b1, cib_pkg::OFS_SBV, 8'h3A);
        bus(1'b1, cib_pkg::OFS_CTRL, 8'h01);
        do @(posedge clk); while (bootValid !== 1'b0);
        waitBoot();
        chk({bootTarget, bootAddr}, {3'b100, 16'h3A00});
        bus(1'b1, cib_pkg::OFS_FUSE, 8'h01);
        bus(1'b1, cib_pkg::OFS_FUSE, 8'h00);
        bus(1'b0, cib_pkg::OFS_FUSE, 8'h00);
        chk(rd, 32'h0000_0001);
        bus(1'b1, cib_pkg::OFS_CTRL, 8'h01);
        @(posedge clk);
        chk({bootValid, bootTarget}, {1'b1, 3'b100});
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_boot();
        t_regs();
        t_session();
        t_restart();
        t_user();
        tally_and_finish();
    end
endmodule

// ---- cib_host_model.sv ----
// Stand-in for the CAN controller and programming host on the far side.
module cib_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // From the session block
    input  wire logic autobaudRun,
    input  wire logic txValid,
    // To the session block
    output logic      baudFound,
    output logic      txReady
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] baudCnt;
    logic [2:0] waitCnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baudCnt   <= 3'h0;
            waitCnt   <= 3'h0;
            baudFound <= 1'b0;
            txReady   <= 1'b0;
        end else begin
            // Timing is found only after several bits have been seen.
            baudCnt   <= autobaudRun ? baudCnt + 3'h1 : 3'h0;
            baudFound <= autobaudRun && (baudCnt == 3'h4);
            // The bus is busy, so a reply waits three cycles before it leaves.
            waitCnt   <= (txValid && !txReady) ? waitCnt + 3'h1 : 3'h0;
            txReady   <= txValid && !txReady && (waitCnt == 3'h2);
        end
    end
endmodule

// ---- cib_pkg.sv ----
// Shared constants and types of the CAN boot session block.
package cib_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the register bus
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_SBV    = 6'h00;
    localparam logic [5:0] OFS_PA     = 6'h04;
    localparam logic [5:0] OFS_PB     = 6'h08;
    localparam logic [5:0] OFS_PC     = 6'h0C;
    localparam logic [5:0] OFS_FUSE   = 6'h10;
    localparam logic [5:0] OFS_EXTRA  = 6'h14;
    localparam logic [5:0] OFS_BT1    = 6'h18;
    localparam logic [5:0] OFS_BT2    = 6'h1C;
    localparam logic [5:0] OFS_BT3    = 6'h20;
    localparam logic [5:0] OFS_BASE   = 6'h24;
    localparam logic [5:0] OFS_NODE   = 6'h28;
    localparam logic [5:0] OFS_STATUS = 6'h2C;
    localparam logic [5:0] OFS_CTRL   = 6'h30;

    // ------------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------------
    localparam int         FUSE_BIT     = 0;
    localparam int         CTRL_RESTART = 0;
    localparam logic [7:0] BYTE_ANY     = 8'hFF;
    localparam logic [7:0] LOW_BYTE     = 8'h00;
    localparam logic [7:0] SESS_CLOSED  = 8'h00;
    localparam logic [7:0] SESS_OPEN    = 8'h01;
    localparam logic [3:0] REPLY_DLC    = 4'h2;
    localparam logic [3:0] DLC_NONE     = 4'h0;
    localparam logic [15:0] APP_ADDR    = 16'h0000;
    localparam logic [15:0] BOOT_ADDR   = 16'hF800;
    localparam logic [3:0] CMD_SELECT   = 4'h0;
    localparam logic [3:0] CMD_PSTART   = 4'h1;
    localparam logic [3:0] CMD_READ     = 4'h5;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] SBV_RST   = 8'hFC;
    localparam logic [7:0] PA_RST    = 8'hFE;
    localparam logic [7:0] PB_RST    = 8'hFF;
    localparam logic [7:0] PC_RST    = 8'hFF;
    localparam logic       FUSE_RST  = 1'b0;
    localparam logic [7:0] EXTRA_RST = 8'hFF;
    localparam logic [7:0] BT_RST    = 8'hFF;
    localparam logic [7:0] NODE_RST  = 8'hFF;
    localparam logic [6:0] BASE_RST  = 7'h00;
    localparam logic [1:0] SETTLE    = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [10:0] id;
        logic        ext;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cib_frame_t;

    typedef struct packed {
        logic [7:0] soft_boot_vector;
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] pc;
        logic       fuse;
    } cib_bootcfg_t;

    typedef enum logic [2:0] {
        TGT_APP  = 3'b001,
        TGT_ISP  = 3'b010,
        TGT_USER = 3'b100
    } cib_target_t;

    typedef enum logic [3:0] {
        ST_BOOT  = 4'b0001,
        ST_BAUD  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_REPLY = 4'b1000
    } cib_phase_t;

    typedef struct packed {
        cib_phase_t   phase;
        logic [1:0]   settle;
        logic [7:0]   pAs1;
        logic [7:0]   pAs2;
        logic [7:0]   pBs1;
        logic [7:0]   pBs2;
        logic [1:0]   pCs1;
        logic [1:0]   pCs2;
        cib_bootcfg_t cfg;
        logic [7:0]   extra;
        logic [7:0]   bt1;
        logic [7:0]   bt2;
        logic [7:0]   bt3;
        logic [7:0]   node;
        logic [6:0]   base;
        logic         session;
        logic         baudOk;
        logic         ackEn;
        logic         autoRun;
        logic         btLoad;
        logic         bootValid;
        cib_target_t  target;
        logic [15:0]  bootAddr;
        logic         txValid;
        cib_frame_t   tx;
        logic         cmdValid;
        cib_frame_t   cmd;
        logic         waitReq;
        logic [31:0]  rdata;
    } cib_state_t;

    localparam cib_state_t RST_STATE = '{
        phase: ST_BOOT, settle: SETTLE, target: TGT_APP, waitReq: 1'b1,
        cfg: '{soft_boot_vector: SBV_RST, pa: PA_RST, pb: PB_RST, pc: PC_RST, fuse: FUSE_RST},
        extra: EXTRA_RST, bt1: BT_RST, bt2: BT_RST, bt3: BT_RST,
        node: NODE_RST, base: BASE_RST, default: '0};

    function automatic logic [3:0] cmdOf(input logic [10:0] id);
        return id[3:0];
    endfunction

    function automatic logic [6:0] baseOf(input logic [10:0] id);
        return id[10:4];
    endfunction

    function automatic logic [10:0] mkId(input logic [6:0] b, input logic [3:0] c);
        return {b, c};
    endfunction

endpackage
